// ==== bps_pkg.sv ====
// Package for the buck protection sequencer: constants, types, timings
package bps_pkg;

   // Clock and timing figures
   localparam int CLK_HZ         = 10_000_000;
   localparam int DETECT_US      = 800;        // Resistor detect time
   localparam int IDLE_MS        = 6;          // Hiccup idle time
   localparam int DETECT_CYC     = DETECT_US * (CLK_HZ / 1_000_000);
   localparam int IDLE_CYC       = IDLE_MS * (CLK_HZ / 1_000);
   localparam int VIOL_LIMIT     = 32;         // Violations before idle
   localparam int RAMP_STEPS     = 255;        // Soft start ramp length
   localparam int DEADTIME_CYC   = 2;          // Anti-overlap gap

   // Gain codes selected by the programming resistor
   localparam logic [1:0] GAIN_X3  = 2'h0;     // 47 kohm
   localparam logic [1:0] GAIN_X6  = 2'h1;     // 22 kohm
   localparam logic [1:0] GAIN_X12 = 2'h2;     // Open
   localparam logic [1:0] GAIN_X24 = 2'h3;     // 100 kohm

   // Resistor classes reported by the detect comparators
   localparam logic [1:0] RCLASS_47K  = 2'h0;
   localparam logic [1:0] RCLASS_22K  = 2'h1;
   localparam logic [1:0] RCLASS_OPEN = 2'h2;
   localparam logic [1:0] RCLASS_100K = 2'h3;

   typedef enum logic [2:0] {
      BPS_DETECT, BPS_SOFT, BPS_RUN, BPS_IDLE, BPS_RETRY, BPS_OFF_DOWN,
      BPS_THERMAL
   } bps_state_t;

   // Analog indications, all asynchronous to clk
   typedef struct packed {
      logic       over_temp_hi;  // Junction above 155 C
      logic       over_temp_lo;  // Junction still above 140 C
      logic       cur_limit;     // Low-side current above setpoint
      logic       comp_fault;    // Error amp shows violation persisting
      logic       pwm_request;   // On-time request from the loop
      logic [1:0] resistor_class; // Digitised programming resistor
   } bps_sense_t;

   // Gate and reference controls
   typedef struct packed {
      logic high_side_gate_drive;
      logic low_side_gate_drive;
      logic detect_ref_en;       // Force 0.4 V onto the low-side pin
   } bps_drive_t;

   function automatic logic [1:0] bps_gain(input logic [1:0] rc);
      case (rc)
         RCLASS_47K:  bps_gain = GAIN_X3;
         RCLASS_22K:  bps_gain = GAIN_X6;
         RCLASS_OPEN: bps_gain = GAIN_X12;
         default:     bps_gain = GAIN_X24;
      endcase
   endfunction : bps_gain

endpackage : bps_pkg

// ==== bps_power_stage_model.sv ====
// Behavioural power stage and analog comparators facing the sequencer
`timescale 1ns/1ns
module bps_power_stage_model
   import bps_pkg::*;
(
   input  wire logic       clk,         // Device clock
   input  wire bps_drive_t drive,       // Gate controls from the device
   input  wire logic       ctrl_enable, // Controller switching
   input  wire logic       short_fault, // Output short applied by the bench
   input  wire logic [1:0] resistor_class, // Fitted programming resistor
   input  wire logic [7:0] temp_c,      // Junction temperature in C
   output bps_sense_t      sense_in     // Comparator outputs
);
   logic [3:0] pwm_cnt;

   ////////////////////////////////////////////////////////////////////////
   // Free-running loop period, so both gate phases keep occurring
   initial pwm_cnt = 4'h0;
   always @(posedge clk) begin
      pwm_cnt <= pwm_cnt + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // A shorted output trips the valley limit once per low-side phase,
   // and keeps the error amp railed while the controller switches
   always_comb begin
      sense_in.over_temp_hi = (temp_c > 8'h9b);
      sense_in.over_temp_lo = (temp_c > 8'h8c);
      sense_in.cur_limit    = short_fault & drive.low_side_gate_drive;
      sense_in.comp_fault   = short_fault & ctrl_enable;
      sense_in.pwm_request  = pwm_cnt[3];
      sense_in.resistor_class = resistor_class;
   end
endmodule : bps_power_stage_model

// ==== bps_sequencer.sv ====
// Buck protection sequencer: detect, soft start, hiccup, thermal, gates
//
// Overview of operation
// - Resistor detection runs at startup and finishes before soft start.
// - During detection low side holds 0.4 V reference, no gate pulses.
// - Detected resistor becomes one of four 2-bit gain codes.
// - 47k gives 3, 22k gives 6, open 12, 100k gives 24 V/V.
// - Over 155 C both gates go off and controller disables at once.
// - Thermal shutdown holds until below 140 C, then operation resumes.
// - Each low-side current above setpoint counts one violation.
// - After 32 violations idle with both switches off for 6 ms.
// - When idle ends soft start restarts and output ramps again.
// - Fault seen on error amp during retry: idle, power down, repeat.
// - Once the violation is gone, return to normal switching.
// - Gates are complementary, never both on, with anti-overlap gap.
// - Detection lasts about 800 us; both gates start with soft start.
// - Soft start counter raises ramp current one step each cycle.
`timescale 1ns/1ns
module bps_sequencer #(
   parameter int DETECT_CYCLES = bps_pkg::DETECT_CYC, // Detect duration
   parameter int IDLE_CYCLES   = bps_pkg::IDLE_CYC,   // Idle duration
   parameter int RAMP_W        = 8                    // Ramp counter width
) (
   input  wire logic               clk,       // 10 MHz clock
   input  wire logic               rst,       // Sync reset, active high
   input  wire bps_pkg::bps_sense_t sense_in, // Analog indications
   output bps_pkg::bps_drive_t     drive,     // Gate and reference controls
   output logic [1:0]              gain_code, // Current-sense gain code
   output logic [RAMP_W-1:0]       ramp_step, // Soft start current steps
   output logic                    ctrl_enable, // Controller enabled
   output logic                    thermal_off  // Thermal shutdown active
);
   import bps_pkg::*;

   localparam int TW = $clog2(IDLE_CYCLES + DETECT_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers; first stage read only by second
   bps_sense_t s_meta;
   bps_sense_t s_sync;
   always_ff @(posedge clk) begin
      s_meta <= sense_in;
      s_sync <= s_meta;
   end

   // Edge of current limit so one long excursion counts once
   logic cl_prev;
   always_ff @(posedge clk) begin
      cl_prev <= rst ? 1'b0 : s_sync.cur_limit;
   end
   wire cl_event = s_sync.cur_limit & ~cl_prev;

   ////////////////////////////////////////////////////////////////////
   // State, timer, counters
   bps_state_t        state;
   bps_state_t        next_state;
   logic [TW-1:0]     timer;
   logic [5:0]        viol_cnt;
   logic              retried;   // Idle came from a failed retry

   wire timer_done  = (timer == TW'(0));
   wire viol_full   = (viol_cnt == 6'(VIOL_LIMIT - 1)) & cl_event;
   wire hot         = s_sync.over_temp_hi;
   wire ramp_done   = (ramp_step == RAMP_W'(RAMP_STEPS));
   wire switching   = (state == BPS_SOFT) | (state == BPS_RUN) |
                      (state == BPS_RETRY);

   // Next state decode
   always_comb begin
      next_state = state;
      case (state)
         BPS_DETECT:   if (timer_done) next_state = BPS_SOFT;
         BPS_SOFT:     if (viol_full) next_state = BPS_IDLE;
                       else if (ramp_done) next_state = BPS_RUN;
         BPS_RUN:      if (viol_full) next_state = BPS_IDLE;
         BPS_IDLE:     if (timer_done) next_state = retried ?
                          BPS_OFF_DOWN : BPS_RETRY;
         BPS_RETRY:    if (s_sync.comp_fault | viol_full)
                          next_state = BPS_IDLE;
                       else if (ramp_done) next_state = BPS_RUN;
         BPS_OFF_DOWN: next_state = BPS_DETECT;
         BPS_THERMAL:  if (!s_sync.over_temp_lo)
                          next_state = BPS_DETECT;
         default:      next_state = BPS_DETECT;
      endcase
      if (hot) next_state = BPS_THERMAL;
   end

   // State register; full power-down restarts from detection
   always_ff @(posedge clk) begin
      if (rst) state <= BPS_DETECT;
      else     state <= next_state;
   end

   // Timer loads on entry to timed states
   wire enter = (next_state != state);
   always_ff @(posedge clk) begin
      if (rst)
         timer <= TW'(DETECT_CYCLES - 1);
      else if (enter && next_state == BPS_IDLE)
         timer <= TW'(IDLE_CYCLES - 1);
      else if (enter && next_state == BPS_DETECT)
         timer <= TW'(DETECT_CYCLES - 1);
      else if (!timer_done)
         timer <= timer - TW'(1);
   end

   // Retry marker: idle after a failed retry leads to power-down
   always_ff @(posedge clk) begin
      if (rst || next_state == BPS_RUN || next_state == BPS_DETECT)
         retried <= 1'b0;
      else if (state == BPS_RETRY && next_state == BPS_IDLE)
         retried <= 1'b1;
   end

   // Violation counter, cleared on idle entry, on retry start and on resuming run
   always_ff @(posedge clk) begin
      if (rst || (enter && (next_state == BPS_RETRY ||
                            next_state == BPS_RUN ||
                            next_state == BPS_IDLE)))
         viol_cnt <= 6'h00;
      else if (switching && cl_event)
         viol_cnt <= viol_cnt + 6'h01;
   end

   // Soft start ramp: one current step per cycle
   always_ff @(posedge clk) begin
      if (rst || !(next_state == BPS_SOFT || next_state == BPS_RETRY))
         ramp_step <= '0;
      else if (!ramp_done)
         ramp_step <= ramp_step + RAMP_W'(1);
   end

   // Gain latched at the end of detection
   always_ff @(posedge clk) begin
      if (rst)
         gain_code <= GAIN_X12;
      else if (state == BPS_DETECT && timer_done)
         gain_code <= bps_gain(s_sync.resistor_class);
   end

   ////////////////////////////////////////////////////////////////////
   // Gate drive with dead time; off state forced when not switching
   logic [1:0] dead;
   wire want_hi = switching & ~hot & s_sync.pwm_request;
   wire want_lo = switching & ~hot & ~s_sync.pwm_request;
   wire dead_ok = (dead == 2'h0);
   wire next_hi = want_hi & ~drive.low_side_gate_drive & dead_ok;
   wire next_lo = want_lo & ~drive.high_side_gate_drive & dead_ok;

   always_ff @(posedge clk) begin
      if (rst) begin
         drive <= '0;
         dead  <= 2'h0;
      end else begin
         drive.high_side_gate_drive <= next_hi;
         drive.low_side_gate_drive  <= next_lo;
         drive.detect_ref_en <= (next_state == BPS_DETECT);
         if ((drive.high_side_gate_drive & ~want_hi) |
             (drive.low_side_gate_drive & ~want_lo))
            dead <= 2'(DEADTIME_CYC);
         else if (!dead_ok)
            dead <= dead - 2'h1;
      end
   end

   // Status outputs
   always_ff @(posedge clk) begin
      ctrl_enable <= rst ? 1'b0 : switching & ~hot;
      thermal_off <= rst ? 1'b0 : (next_state == BPS_THERMAL);
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_no_overlap;
      @(posedge clk) disable iff (rst)
      !(drive.high_side_gate_drive && drive.low_side_gate_drive);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("both gates on");

   // A gate turning off leaves both off through the dead time
   property p_dead_gap;
      @(posedge clk) disable iff (rst)
      ($fell(drive.high_side_gate_drive) || $fell(drive.low_side_gate_drive))
         |-> (!drive.high_side_gate_drive && !drive.low_side_gate_drive) [*3];
   endproperty
   a_dead_gap: assert property (p_dead_gap)
      else $error("no dead time between gate phases");

   property p_detect_quiet;
      @(posedge clk) disable iff (rst)
      drive.detect_ref_en |-> !drive.low_side_gate_drive &&
                              !drive.high_side_gate_drive;
   endproperty
   a_detect_quiet: assert property (p_detect_quiet)
      else $error("gate pulse during detection");

   property p_hot_off;
      @(posedge clk) disable iff (rst)
      hot |=> !drive.high_side_gate_drive && !drive.low_side_gate_drive
              && state == BPS_THERMAL;
   endproperty
   a_hot_off: assert property (p_hot_off)
      else $error("gates not off on over temperature");

   property p_thermal_exit;
      @(posedge clk) disable iff (rst)
      (state == BPS_THERMAL && !s_sync.over_temp_lo && !hot)
         |=> state == BPS_DETECT;
   endproperty
   a_thermal_exit: assert property (p_thermal_exit)
      else $error("thermal shutdown not left");

   property p_idle_entry;
      @(posedge clk) disable iff (rst)
      (state == BPS_RUN && viol_full && !hot) |=> state == BPS_IDLE;
   endproperty
   a_idle_entry: assert property (p_idle_entry)
      else $error("no idle after violation limit");

   property p_idle_off;
      @(posedge clk) disable iff (rst)
      (state == BPS_IDLE) |=> !drive.high_side_gate_drive &&
                              !drive.low_side_gate_drive;
   endproperty
   a_idle_off: assert property (p_idle_off)
      else $error("switch on while idle");

   property p_soft_after_detect;
      @(posedge clk) disable iff (rst)
      (state == BPS_DETECT && !timer_done && !hot) |=> state == BPS_DETECT;
   endproperty
   a_soft_after_detect: assert property (p_soft_after_detect)
      else $error("soft start before detection ended");

   property p_ramp_step;
      @(posedge clk) disable iff (rst)
      (state == BPS_SOFT && $past(state) == BPS_SOFT && !ramp_done &&
       !viol_full && !hot)
         |=> ramp_step == $past(ramp_step) + RAMP_W'(1);
   endproperty
   a_ramp_step: assert property (p_ramp_step)
      else $error("ramp not stepping");

   property p_retry_clear;
      @(posedge clk) disable iff (rst)
      (state == BPS_IDLE && timer_done && !retried && !hot)
         |=> viol_cnt == 6'h00 && state == BPS_RETRY;
   endproperty
   a_retry_clear: assert property (p_retry_clear)
      else $error("retry without cleared count");

endmodule : bps_sequencer

// ==== test_bps_sequencer.sv ====
// Self-checking testbench for the buck protection sequencer
`timescale 1ns/1ns
module test_bps_sequencer;
   import bps_pkg::*;
   localparam int DET = 20;        // Shortened detect time
   localparam int IDL = 50;        // Shortened idle time
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       short_fault = 1'b0;
   logic [7:0] temp_c = 8'h19;
   logic [1:0] resistor_class = 2'h0;
   bps_sense_t sense_in;
   bps_drive_t drive;
   logic [1:0] gain_code;
   logic [7:0] ramp_step;
   logic       ctrl_enable;
   logic       thermal_off;
   int         n_mismatch = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         viol = 0;
   logic [1:0] gain_exp [4] = '{GAIN_X3, GAIN_X6, GAIN_X12, GAIN_X24};

   bps_sequencer #(.DETECT_CYCLES(DET), .IDLE_CYCLES(IDL), .RAMP_W(8))
   bps_sequencer_i (.clk(clk), .rst(rst), .sense_in(sense_in),
      .drive(drive), .gain_code(gain_code), .ramp_step(ramp_step),
      .ctrl_enable(ctrl_enable), .thermal_off(thermal_off));

   bps_power_stage_model bps_power_stage_model_i (.clk(clk),
      .drive(drive), .ctrl_enable(ctrl_enable),
      .short_fault(short_fault), .resistor_class(resistor_class),
      .temp_c(temp_c), .sense_in(sense_in));

   ////////////////////////////////////////////////////////////////////////
   // Clock, cycle ceiling, overlap watch and violation count
   always #50 clk = ~clk;
   always @(negedge clk) begin
      if (drive.high_side_gate_drive === 1'b1)
         check(drive.low_side_gate_drive, 1'b0, "gate overlap");
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run;
      end
   end
   always @(posedge sense_in.cur_limit) viol++;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: %s seen %h want %h", $time, what, seen, exp);
      end
   endtask : check

   // Inputs always change 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic wait_en(input logic lvl, input int lim);
      while (ctrl_enable !== lvl && lim > 0) begin
         step(1);
         lim--;
      end
      check(ctrl_enable, lvl, "enable wait");
   endtask : wait_en

   task automatic wait_ramp_top;
      for (int i = 0; i < DET + 300 && ramp_step !== 8'hff; i++) step(1);
      check(ramp_step, 8'hff, "ramp top");
   endtask : wait_ramp_top

   ////////////////////////////////////////////////////////////////////////
   // Every resistor class, detect phase, then the ramp
   task automatic test_detect;
      int w;
      for (int k = 0; k < 4; k++) begin
         resistor_class = k[1:0];
         rst = 1'b1;
         step(16);
         rst = 1'b0;
         step(2);
         check(drive.detect_ref_en, 1'b1, "ref forced");
         check({drive.high_side_gate_drive, drive.low_side_gate_drive},
               2'h0, "no pulses in detect");
         check(ctrl_enable, 1'b0, "no soft start yet");
         for (w = 2; w < DET + 10 && ctrl_enable !== 1'b1; w++) step(1);
         check(w >= DET, 1'b1, "detect length");
         check(drive.detect_ref_en, 1'b0, "ref released");
         check(gain_code, gain_exp[k], "gain code");
      end
      w = ramp_step;
      step(1);
      check(ramp_step, w[7:0] + 8'h01, "ramp step");
      wait_ramp_top;
      $display("test_detect done");
   endtask : test_detect

   ////////////////////////////////////////////////////////////////////////
   // Hiccup: count, idle, failed retry, power-down, clean retry
   task automatic test_hiccup;
      viol = 0;
      short_fault = 1'b1;
      wait_en(1'b0, 700);
      check(viol, 32, "violations to idle");
      step(2);
      for (int i = 0; i < IDL - 6; i++) begin
         check({drive.high_side_gate_drive, drive.low_side_gate_drive},
               2'h0, "idle gates");
         step(1);
      end
      wait_en(1'b1, 12);
      wait_en(1'b0, 12);
      for (int i = 0; i < IDL + 20 && drive.detect_ref_en !== 1'b1; i++)
         step(1);
      check(drive.detect_ref_en, 1'b1, "power-down redetect");
      short_fault = 1'b0;
      wait_ramp_top;
      short_fault = 1'b1;
      wait_en(1'b0, 700);
      short_fault = 1'b0;
      wait_en(1'b1, IDL + 10);
      wait_ramp_top;
      step(60);
      check(ctrl_enable, 1'b1, "normal switching");
      $display("test_hiccup done");
   endtask : test_hiccup

   ////////////////////////////////////////////////////////////////////////
   // Thermal entry, hysteresis band, exit
   task automatic test_thermal;
      temp_c = 8'ha0;
      step(4);
      check(thermal_off, 1'b1, "thermal entry");
      step(1);
      check({drive.high_side_gate_drive, drive.low_side_gate_drive,
             ctrl_enable}, 3'h0, "thermal off");
      temp_c = 8'h96;
      step(20);
      check(thermal_off, 1'b1, "hysteresis hold");
      temp_c = 8'h82;
      step(4);
      check(thermal_off, 1'b0, "thermal exit");
      wait_en(1'b1, DET + 10);
      $display("test_thermal done");
   endtask : test_thermal

   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   initial begin
      test_detect;
      test_hiccup;
      test_thermal;
      complete_run;
   end
endmodule : test_bps_sequencer
